// *** rtl/padc_core.sv ***
`timescale 1ns/1ns
module padc_core #(
  parameter int DATA_WIDTH = padc_pkg::DATA_WIDTH,
  parameter int LEVEL_WIDTH = padc_pkg::LEVEL_WIDTH
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic sleep_request_pin,
  input wire logic [LEVEL_WIDTH-1:0] input_level,
  input wire logic [LEVEL_WIDTH-1:0] lower_reference_level,
  input wire logic [LEVEL_WIDTH-1:0] upper_reference_level,
  output logic [DATA_WIDTH-1:0] sample_word_bits
);

  // the clamp codes and the scale factor are fixed eight-bit package words
  if (DATA_WIDTH != padc_pkg::DATA_WIDTH)
  begin : g_bad_data_width
    $error("padc_core: DATA_WIDTH must equal the package word width");
  end

  // a level narrower than the word could not reach every code
  if (LEVEL_WIDTH < DATA_WIDTH)
  begin : g_bad_level_width
    $error("padc_core: LEVEL_WIDTH must not be below DATA_WIDTH");
  end

  // the pipe below is built from exactly three rising-edge stages
  if (padc_pkg::OUTPUT_RISE_EDGES != 3)
  begin : g_bad_latency
    $error("padc_core: pipe depth does not match the half-cycle latency");
  end

  localparam int PROD_WIDTH = LEVEL_WIDTH + DATA_WIDTH;

  logic [DATA_WIDTH-1:0] capture_reg;
  logic [DATA_WIDTH-1:0] stage1_reg;
  logic [DATA_WIDTH-1:0] stage2_reg;
  logic [DATA_WIDTH-1:0] word_reg;

  // quantiser: clamp at the reference limits, then scale linearly
  wire below_range = input_level < lower_reference_level;
  wire above_range = input_level > upper_reference_level;
  wire empty_span = upper_reference_level <= lower_reference_level;
  wire in_range = !below_range && !above_range && !empty_span;
  wire [LEVEL_WIDTH-1:0] span = upper_reference_level - lower_reference_level;
  wire [LEVEL_WIDTH-1:0] offset = input_level - lower_reference_level;
  wire [PROD_WIDTH-1:0] scaled = PROD_WIDTH'(offset) * PROD_WIDTH'(padc_pkg::WORD_FULL);
  wire [PROD_WIDTH-1:0] quotient = empty_span ? '0 : scaled / PROD_WIDTH'(span);
  wire [DATA_WIDTH-1:0] ratio_code = quotient[DATA_WIDTH-1:0];
  wire [DATA_WIDTH-1:0] code_word;
  // zero code for low input, full code for high or degenerate span
  assign code_word = below_range ? padc_pkg::WORD_ZERO :
                     (above_range || empty_span) ? padc_pkg::WORD_FULL :
                     ratio_code;

  wire awake = !sleep_request_pin;

  // capture on the falling edge; a stopped clock simply holds everything
  always_ff @(negedge clk or posedge reset)
  begin
    if (reset)
      capture_reg <= padc_pkg::WORD_RESET;
    else if (awake)
      capture_reg <= code_word;
  end

  // two more rising edges of pipeline plus the output stage give 2.5 cycles
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      stage1_reg <= padc_pkg::WORD_RESET;
      stage2_reg <= padc_pkg::WORD_RESET;
      word_reg <= padc_pkg::WORD_RESET;
    end
    else if (awake)
    begin
      stage1_reg <= capture_reg;
      stage2_reg <= stage1_reg;
      word_reg <= stage2_reg;
    end
  end

  // freezing the whole pipe during sleep keeps the last word on the pins
  assign sample_word_bits = word_reg;

  // helper: the word as seen at the last falling edge, for the rise-only check
  logic [DATA_WIDTH-1:0] fall_word_reg;
  always_ff @(negedge clk or posedge reset)
  begin
    if (reset)
      fall_word_reg <= padc_pkg::WORD_RESET;
    else
      fall_word_reg <= sample_word_bits;
  end

  // helper: the rising-edge count of the pipe must match the half-cycle latency
  localparam int RISE_EDGES = padc_pkg::OUTPUT_RISE_EDGES;

  sequence awake_run;
    (!sleep_request_pin)[*3];
  endsequence

  sequence asleep_run;
    sleep_request_pin[*2];
  endsequence

  sequence sleep_entry;
    !sleep_request_pin ##1 sleep_request_pin;
  endsequence

  sequence wake_edge;
    sleep_request_pin ##1 !sleep_request_pin;
  endsequence

  sequence awake_falls;
    (!sleep_request_pin)[*4];
  endsequence

  chk_zero_below_ref: assert property (
    @(posedge clk) disable iff (reset)
    (input_level < lower_reference_level) |-> (code_word == padc_pkg::WORD_ZERO))
    else $error("input below lower reference did not give zero code");

  chk_full_above_ref: assert property (
    @(posedge clk) disable iff (reset)
    (input_level > upper_reference_level) |-> (code_word == padc_pkg::WORD_FULL))
    else $error("input above upper reference did not give full code");

  chk_binary_end_points: assert property (
    @(posedge clk) disable iff (reset)
    ((!empty_span && input_level == upper_reference_level) |-> (code_word == padc_pkg::WORD_FULL))
    and ((input_level == lower_reference_level && !empty_span) |-> (code_word == padc_pkg::WORD_ZERO)))
    else $error("end points of the range not coded as straight binary");

  chk_code_monotonic: assert property (
    @(posedge clk) disable iff (reset)
    ($stable(lower_reference_level) && $stable(upper_reference_level)
     && input_level > $past(input_level)) |-> (code_word >= $past(code_word)))
    else $error("code fell while the input level rose");

  chk_capture_falling: assert property (
    @(negedge clk) disable iff (reset)
    (!sleep_request_pin) |=> (capture_reg == $past(code_word)))
    else $error("falling edge did not capture the quantised sample");

  chk_pipe_latency: assert property (
    @(posedge clk) disable iff (reset)
    awake_run |=> (sample_word_bits == $past(capture_reg, 3)))
    else $error("output word not the capture from 2.5 cycles earlier");

  chk_continuous_advance: assert property (
    @(posedge clk) disable iff (reset)
    (!sleep_request_pin) |=> (stage1_reg == $past(capture_reg)) && (stage2_reg == $past(stage1_reg)))
    else $error("pipeline did not advance while awake");

  chk_sleep_holds_word: assert property (
    @(posedge clk) disable iff (reset)
    sleep_request_pin |=> $stable(sample_word_bits))
    else $error("output word changed during sleep");

  chk_sleep_freezes_pipe: assert property (
    @(posedge clk) disable iff (reset)
    asleep_run |-> $stable(stage2_reg) && $stable(stage1_reg))
    else $error("pipeline moved during sleep");

  // the word just before a rise must equal the word seen at the fall before it
  chk_word_rise_only: assert property (
    @(posedge clk) disable iff (reset)
    sample_word_bits == fall_word_reg)
    else $error("output word changed away from a rising edge");

  // end to end, quantiser to pins, counted in falling edges
  chk_latency_edges: assert property (
    @(negedge clk) disable iff (reset)
    awake_falls |-> (sample_word_bits == $past(code_word, RISE_EDGES)))
    else $error("output word is not the sample captured 2.5 cycles earlier");

  // cross-multiplied so the check does not lean on the divider
  chk_ratio_bounds: assert property (
    @(posedge clk) disable iff (reset)
    in_range |-> (PROD_WIDTH'(code_word) * PROD_WIDTH'(span) <= scaled)
      && (scaled < (PROD_WIDTH'(code_word) + PROD_WIDTH'(1)) * PROD_WIDTH'(span)))
    else $error("in-range code is not the truncated span ratio");

  chk_full_code_ceiling: assert property (
    @(posedge clk) disable iff (reset)
    (code_word == padc_pkg::WORD_FULL) |-> (input_level >= upper_reference_level || empty_span))
    else $error("full code given below the upper reference level");

  chk_zero_code_floor: assert property (
    @(posedge clk) disable iff (reset)
    (code_word == padc_pkg::WORD_ZERO && in_range) |-> (scaled < PROD_WIDTH'(span)))
    else $error("zero code given above the first code step");

  chk_flat_span_full: assert property (
    @(posedge clk) disable iff (reset)
    (empty_span && !below_range) |-> (code_word == padc_pkg::WORD_FULL))
    else $error("degenerate span did not give full code");

  chk_sleep_holds_capture: assert property (
    @(negedge clk) disable iff (reset)
    sleep_request_pin |=> $stable(capture_reg))
    else $error("capture register moved during sleep");

  chk_sleep_entry_word: assert property (
    @(posedge clk) disable iff (reset)
    sleep_entry |=> $stable(sample_word_bits))
    else $error("output word moved on entry to sleep");

  chk_wake_first_step: assert property (
    @(posedge clk) disable iff (reset)
    wake_edge |=> (stage1_reg == $past(capture_reg)))
    else $error("pipeline did not restart on wake");

  chk_awake_output_step: assert property (
    @(posedge clk) disable iff (reset)
    (!sleep_request_pin) |=> (sample_word_bits == $past(stage2_reg)))
    else $error("output stage did not follow the pipe while awake");

endmodule

// *** common/padc_pkg.sv ***
package padc_pkg;
  localparam int DATA_WIDTH = 8;
  localparam int LEVEL_WIDTH = 16;
  localparam int CLK_PERIOD_NS = 100;
  localparam int LATENCY_HALF_CYCLES = 5;
  localparam int OUTPUT_RISE_EDGES = (LATENCY_HALF_CYCLES + 1) / 2;
  localparam int WAKE_TIME_NS = 1000;
  localparam int WAKE_CYCLES = WAKE_TIME_NS / CLK_PERIOD_NS;
  localparam logic [DATA_WIDTH-1:0] WORD_RESET = 8'h00;
  localparam logic [DATA_WIDTH-1:0] WORD_ZERO = 8'h00;
  localparam logic [DATA_WIDTH-1:0] WORD_FULL = 8'hff;
endpackage

// *** sim/padc_rx_model.sv ***
`timescale 1ns/1ns
module padc_rx_model (
  input wire logic clk,
  input wire logic reset,
  input wire logic sleep_request_pin,
  input wire logic [7:0] sample_word_bits,
  output logic rx_valid,
  output logic [7:0] rx_word_reg
);
  // words are taken on the falling edge, well past the output delay
  int skip_count;
  always_ff @(negedge clk or posedge reset)
  begin
    if (reset)
      skip_count <= padc_pkg::WAKE_CYCLES;
    else if (sleep_request_pin)
      skip_count <= padc_pkg::WAKE_CYCLES;
    else if (skip_count > 0)
      skip_count <= skip_count - 1;
  end
  assign rx_valid = (skip_count == 0);
  // only words past the settling window are registered
  always_ff @(negedge clk or posedge reset)
  begin
    if (reset)
      rx_word_reg <= 8'h00;
    else if (rx_valid)
      rx_word_reg <= sample_word_bits;
  end
endmodule

// *** sim/pipelined_adc_output_port_tb.sv ***
`timescale 1ns/1ns
module pipelined_adc_output_port_tb;
  logic clk = 1'b0;
  logic clk_run = 1'b1;
  logic reset = 1'b1;
  logic sleep_request_pin = 1'b0;
  logic [15:0] input_level = 16'h0000;
  logic [15:0] lower_reference_level = 16'h0010;
  logic [15:0] upper_reference_level = 16'h010f;
  logic [7:0] sample_word_bits;
  logic rx_valid;
  logic [7:0] rx_word_reg;
  int n_errors = 0;
  int total_checks = 0;
  padc_core i_dut (.clk, .reset, .sleep_request_pin, .input_level, .lower_reference_level,
    .upper_reference_level, .sample_word_bits);
  padc_rx_model i_rx (.clk, .reset, .sleep_request_pin, .sample_word_bits, .rx_valid, .rx_word_reg);
  initial
  begin
    forever #50 clk = clk_run ? ~clk : clk;
  end
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // clamps first, then scales the span onto the full code range
  function automatic logic [7:0] code_of(input logic [15:0] lv);
    if (lv < lower_reference_level)
      return 8'h00;
    if (lv > upper_reference_level)
      return 8'hff;
    return 8'((32'(lv - lower_reference_level) * 255) / 32'(upper_reference_level - lower_reference_level));
  endfunction
  task automatic run_stream();
    logic [15:0] lv[10] = '{16'h0000, 16'h000f, 16'h0010, 16'h0011, 16'h0090, 16'h010e, 16'h010f,
      16'h0110, 16'hffff, 16'h0055};
    logic [7:0] exp_q[$];
    for (int i = 0; i < 14; i++)
    begin
      @(negedge clk);
      if (i >= 4)
        check("stream word", sample_word_bits, exp_q.pop_front());
      input_level <= lv[i % 10];
      exp_q.push_back(code_of(lv[i % 10]));
    end
  endtask
  task automatic run_sleep();
    logic [7:0] held;
    @(negedge clk);
    held = sample_word_bits;
    sleep_request_pin <= 1'b1;
    input_level <= 16'h0100;
    repeat (6)
    begin
      @(negedge clk);
      check("sleep hold", sample_word_bits, held);
    end
    sleep_request_pin <= 1'b0;
    @(negedge clk);
    check("wake valid", {7'h00, rx_valid}, 8'h00);
    for (int k = 0; k < 20 && rx_valid !== 1'b1; k++)
      @(negedge clk);
    check("wake settle", {7'h00, rx_valid}, 8'h01);
    check("wake word", sample_word_bits, 8'hf0);
    @(negedge clk);
    check("partner word", rx_word_reg, 8'hf0);
  endtask
  task automatic run_flat_span();
    @(negedge clk);
    upper_reference_level <= 16'h0010;
    input_level <= 16'h0020;
    repeat (4) @(negedge clk);
    check("flat span", sample_word_bits, 8'hff);
    upper_reference_level <= 16'h010f;
  endtask
  task automatic run_clock_stop();
    logic [7:0] held;
    @(negedge clk);
    held = sample_word_bits;
    input_level <= 16'h0000;
    clk_run = 1'b0;
    #1000;
    check("stopped clock", sample_word_bits, held);
    clk_run = 1'b1;
  endtask
  initial
  begin
    repeat (10) @(negedge clk);
    reset <= 1'b0;
    run_stream();
    run_flat_span();
    run_sleep();
    run_clock_stop();
    stop_test();
  end
endmodule
